// file: hw/osel_top.sv
// oscillator source enable logic with its register slave
//
// Chosen here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module osel_top #(
   parameter int FAST_SETTLE_CYC = 16
) (
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   input wire logic osc_in_i,
   input wire logic sec_osc_tick_i,
   input wire logic slow_osc_tick_i,
   input wire logic fast_osc_tick_i,
   input wire logic gpio_out_i,
   input wire logic gpio_oe_b_i,
   output logic osc_out_o,
   output logic osc_out_oe_b_o,
   output logic osc_in_is_gpio_o,
   output logic primary_osc_en_o,
   output logic [1:0] amp_gain_o,
   output logic sec_osc_en_o,
   output logic slow_osc_en_o,
   output logic fast_osc_en_o,
   output logic slow_timers_tick_o,
   output logic sys_tick_o,
   output osel_pkg::osel_mode_t primary_osc_mode_o
);
   import osel_pkg::*;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic [1:0] rst_sync;
   logic rst_b;

   // async assert, release through two flops
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_b = rst_sync[1];

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   logic [CFG_W-1:0] cfg;
   logic [CTRL_W-1:0] ctrl;
   logic [31:0] stat;
   logic wr_pend;
   logic rd_pend;
   logic [7:0] dp_addr;
   logic addr_ok;

   // only whole-word single transfers are expected; others still answer okay
   assign addr_ok = hsel_i && hready_i && htrans_i[1];
   assign hresp_o = 1'b0;
   // reads take one wait state so data always comes from a flop
   assign hreadyout_o = !rd_pend;

   // data-phase bookkeeping
   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         wr_pend <= 1'b0;
         rd_pend <= 1'b0;
         dp_addr <= 8'h00;
      end else begin
         wr_pend <= addr_ok && hwrite_i;
         rd_pend <= addr_ok && !hwrite_i;
         if (addr_ok) begin
            dp_addr <= haddr_i[7:0];
         end
      end
   end

   // read data captured in the wait cycle, after any earlier write landed
   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         hrdata_o <= RD_ZERO;
      end else if (rd_pend) begin
         case (dp_addr)
            CFG_OFS: hrdata_o <= {{(32-CFG_W){1'b0}}, cfg};
            CTRL_OFS: hrdata_o <= {{(32-CTRL_W){1'b0}}, ctrl};
            STAT_OFS: hrdata_o <= stat;
            default: hrdata_o <= RD_ZERO;
         endcase
      end
   end

   // reset to primary
   // software-written registers; unmapped writes are dropped
   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         cfg <= CFG_RST;
         ctrl <= CTRL_RST;
      end else if (wr_pend) begin
         if (dp_addr == CFG_OFS) begin
            cfg <= hwdata_i[CFG_W-1:0];
         end
         if (dp_addr == CTRL_OFS) begin
            ctrl <= hwdata_i[CTRL_W-1:0];
         end
      end
   end

   // ------------------------------------------------------------
   // configuration decode
   // ------------------------------------------------------------
   osel_mode_t mode;
   logic [1:0] css;
   logic [2:0] ifs;
   logic sw_allow, run_bit, two_spd, fscm, pwrt_n, wdt_hw, wdt_sw, ssff;
   logic mode_int, mode_rc, mode_ext_clk, mode_qclk, use_internal, slow_pick, int_use;

   assign mode = osel_mode_t'(cfg[CFG_MODE_LSB +: 4]);
   assign primary_osc_mode_o = mode;
   assign sw_allow = cfg[CFG_SWCTL_BIT];
   assign two_spd = cfg[CFG_TWOSPD_BIT];
   assign fscm = cfg[CFG_FSCM_BIT];
   assign pwrt_n = cfg[CFG_PWRTN_BIT];
   assign wdt_hw = cfg[CFG_WDTHW_BIT];
   assign css = ctrl[CTRL_CSS_LSB +: 2];
   assign ifs = ctrl[CTRL_IFS_LSB +: 3];
   assign run_bit = ctrl[CTRL_RUN_BIT];
   assign ssff = ctrl[CTRL_SSFF_BIT];
   assign wdt_sw = ctrl[CTRL_WDTSW_BIT];

   assign mode_int = (mode == internal_io_mode) || (mode == internal_qclk_mode);
   assign mode_rc = (mode == rc_io_mode) || (mode == rc_qclk_mode);
   assign mode_ext_clk = (mode >= ext_logic_clock_mode_low) && (mode <= ext_logic_clock_qclk_high);
   assign mode_qclk = (mode == rc_qclk_mode) || (mode == internal_qclk_mode) ||
                      (mode >= ext_logic_clock_qclk_low && mode <= ext_logic_clock_qclk_high);

   assign use_internal = css[CSS_INTERNAL_BIT] || (css == CSS_PRIMARY && mode_int);
   assign slow_pick = (ifs == IFS_SLOW) && !ssff;
   assign int_use = css[CSS_INTERNAL_BIT] || mode_int || two_spd;

   // ------------------------------------------------------------
   // oscillator enables (registered outputs)
   // ------------------------------------------------------------
   logic prim_sel, next_prim_en, next_slow_en, next_fast_en;
   logic [1:0] next_gain;

   assign prim_sel = (css == CSS_PRIMARY) && !mode_int;

   always_comb begin
      // never stop a running primary or internal system clock
      next_prim_en = !mode_int && (prim_sel || !sw_allow || run_bit);
      next_slow_en = !pwrt_n || wdt_hw || wdt_sw || fscm || (slow_pick && int_use);
      next_fast_en = !slow_pick && (int_use || fscm);
      case (mode)
         low_gain_crystal_mode: next_gain = GAIN_LOW;
         mid_gain_crystal_mode: next_gain = GAIN_MID;
         high_gain_crystal_mode: next_gain = GAIN_HIGH;
         default: next_gain = GAIN_OFF;
      endcase
   end

   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         primary_osc_en_o <= 1'b0;
         sec_osc_en_o <= 1'b0;
         slow_osc_en_o <= 1'b0;
         fast_osc_en_o <= 1'b0;
         amp_gain_o <= GAIN_OFF;
      end else begin
         primary_osc_en_o <= next_prim_en;
         sec_osc_en_o <= ctrl[CTRL_SEC_BIT];
         slow_osc_en_o <= next_slow_en;
         fast_osc_en_o <= next_fast_en;
         amp_gain_o <= next_gain;
      end
   end

   // ------------------------------------------------------------
   // fast oscillator settle and postscaler
   // ------------------------------------------------------------
   localparam int SETTLE_W = $clog2(FAST_SETTLE_CYC + 1);
   localparam logic [SETTLE_W-1:0] SETTLE_END = SETTLE_W'(FAST_SETTLE_CYC);
   logic [SETTLE_W-1:0] settle_cnt;
   logic fast_stable;
   logic [PS_W-1:0] ps_cnt;
   logic ps_tick;

   // stable after enable has held for the settle time
   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         settle_cnt <= '0;
         fast_stable <= 1'b0;
      end else if (!fast_osc_en_o) begin
         settle_cnt <= '0;
         fast_stable <= 1'b0;
      end else if (settle_cnt != SETTLE_END) begin
         settle_cnt <= settle_cnt + 1'b1;
      end else begin
         fast_stable <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         ps_cnt <= '0;
      end else if (fast_osc_tick_i && fast_osc_en_o) begin
         ps_cnt <= ps_cnt + 1'b1;
      end
   end
   assign ps_tick = fast_osc_tick_i && fast_osc_en_o && ((ps_cnt & ps_mask(ifs)) == ps_mask(ifs));

   // ------------------------------------------------------------
   // active source and quarter clock
   // ------------------------------------------------------------
   logic osc_in_q, prim_tick, int_tick, act_tick;
   osel_qclk_if q_if ();

   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         osc_in_q <= 1'b0;
      end else begin
         osc_in_q <= osc_in_i;
      end
   end
   // rising edge of the external crystal, rc or logic clock
   assign prim_tick = osc_in_i && !osc_in_q && primary_osc_en_o;
   // internal clock: 31 kHz slow oscillator, else the fast postscaler output at the IFS rate
   assign int_tick = slow_pick ? (slow_osc_tick_i && slow_osc_en_o) : ps_tick;

   always_comb begin
      if (use_internal) begin
         act_tick = int_tick;
      end else if (css == CSS_SECONDARY) begin
         act_tick = sec_osc_tick_i && sec_osc_en_o;
      end else begin
         act_tick = prim_tick;
      end
   end

   assign q_if.tick = act_tick;

   osel_div4 u_div4 (
      .clk_i(mclk_i),
      .rst_b_i(rst_b),
      .q_if(q_if.div)
   );

   always_ff @(posedge mclk_i or negedge rst_b) begin
      if (!rst_b) begin
         osc_out_o <= 1'b0;
         osc_out_oe_b_o <= 1'b1;
         osc_in_is_gpio_o <= 1'b0;
         sys_tick_o <= 1'b0;
         slow_timers_tick_o <= 1'b0;
      end else begin
         osc_out_o <= mode_qclk ? q_if.qclk : gpio_out_i;
         osc_out_oe_b_o <= mode_qclk ? 1'b0 : gpio_oe_b_i;
         osc_in_is_gpio_o <= mode_int;
         sys_tick_o <= act_tick;
         // slow clock for timers and monitor
         slow_timers_tick_o <= slow_osc_tick_i && slow_osc_en_o;
      end
   end

   // status word
   assign stat = {25'h0000000, amp_gain_o, sec_osc_en_o, primary_osc_en_o,
                  fast_osc_en_o, slow_osc_en_o, fast_stable};

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b);

   prim_keep_a: assert property (prim_sel |=> primary_osc_en_o)
      else $error("primary oscillator stopped while selected");
   prim_sd_a: assert property (!mode_int && !prim_sel && sw_allow && !run_bit |=> !primary_osc_en_o)
      else $error("primary oscillator not shut down");
   crystal_gain_a: assert property (mode == high_gain_crystal_mode |=> amp_gain_o == GAIN_HIGH)
      else $error("wrong amplifier gain");
   // rc and logic clock modes leave the amplifier off
   rc_gain_a: assert property (mode_rc || mode_ext_clk |=> amp_gain_o == GAIN_OFF)
      else $error("amplifier on outside crystal modes");
   sec_en_a: assert property (ctrl[CTRL_SEC_BIT] != sec_osc_en_o |=> $changed(sec_osc_en_o))
      else $error("secondary enable does not follow");
   slow_wdt_a: assert property (wdt_sw |=> slow_osc_en_o)
      else $error("slow oscillator off with watchdog on");
   slow_int_a: assert property (css[1] && slow_pick |=> slow_osc_en_o && !fast_osc_en_o)
      else $error("slow selection enables wrong oscillator");
   fast_en_a: assert property (ifs != IFS_SLOW && css[1] |=> fast_osc_en_o)
      else $error("fast oscillator not enabled");
   stable_flag_a: assert property (!fast_osc_en_o |=> !fast_stable)
      else $error("stable flag without fast oscillator");
   qclk_pin_a: assert property (mode_qclk && $stable(mode) |=> !osc_out_oe_b_o && osc_out_o == $past(q_if.qclk))
      else $error("quarter clock not on out pin");
   io_pin_a: assert property (mode_int |=> osc_in_is_gpio_o)
      else $error("in pin not released to io");
   ps_div_a: assert property (ifs == 3'h7 && fast_osc_en_o && fast_osc_tick_i |-> ps_tick)
      else $error("16 MHz setting drops fast ticks");
   // quarter clock may only move after a source tick, never in between
   qclk_div_a: assert property (!act_tick |=> $stable(q_if.qclk))
      else $error("quarter clock moved without a source tick");

   rd_cov: cover property (rd_pend ##1 hreadyout_o);
   int_cov: cover property (use_internal && fast_stable && ps_tick);
   shut_cov: cover property ($fell(primary_osc_en_o));
   qclk_cov: cover property (mode_qclk && $rose(osc_out_o));
endmodule // osel_top

// file: inc/osel_pkg.sv
// constants and types of the oscillator source enable logic
package osel_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses, low address bits decoded)
   // ------------------------------------------------------------
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_SWCTL_BIT = 4;
   localparam int CFG_TWOSPD_BIT = 5;
   localparam int CFG_FSCM_BIT = 6;
   localparam int CFG_PWRTN_BIT = 7;
   localparam int CFG_WDTHW_BIT = 8;
   localparam int CTRL_CSS_LSB = 0;
   localparam int CTRL_IFS_LSB = 2;
   localparam int CTRL_RUN_BIT = 5;
   localparam int CTRL_SEC_BIT = 6;
   localparam int CTRL_SSFF_BIT = 7;
   localparam int CTRL_WDTSW_BIT = 8;
   localparam int CFG_W = 9;
   localparam int CTRL_W = 9;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [8:0] CFG_RST = 9'h080;   // low gain crystal, power-up timer off
   localparam logic [8:0] CTRL_RST = 9'h02C;  // primary selected, 1 MHz, primary run

   // ------------------------------------------------------------
   // encodings
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      low_gain_crystal_mode,
      mid_gain_crystal_mode,
      high_gain_crystal_mode,
      rc_io_mode,
      rc_qclk_mode,
      ext_logic_clock_mode_low,
      ext_logic_clock_mode_mid,
      ext_logic_clock_mode_high,
      ext_logic_clock_qclk_low,
      ext_logic_clock_qclk_mid,
      ext_logic_clock_qclk_high,
      internal_io_mode,
      internal_qclk_mode
   } osel_mode_t;

   localparam logic [1:0] CSS_PRIMARY = 2'h0;
   localparam logic [1:0] CSS_SECONDARY = 2'h1;
   localparam int CSS_INTERNAL_BIT = 1;
   localparam logic [2:0] IFS_SLOW = 3'h0;
   localparam logic [1:0] GAIN_OFF = 2'h0;
   localparam logic [1:0] GAIN_LOW = 2'h1;
   localparam logic [1:0] GAIN_MID = 2'h2;
   localparam logic [1:0] GAIN_HIGH = 2'h3;
   localparam int PS_W = 9;

   // postscaler mask: output tick every (mask+1) fast oscillator ticks
   function automatic logic [8:0] ps_mask(input logic [2:0] ifs);
      case (ifs)
         3'h7: ps_mask = 9'h000;   // 16 MHz
         3'h6: ps_mask = 9'h001;   // 8 MHz
         3'h5: ps_mask = 9'h003;   // 4 MHz
         3'h4: ps_mask = 9'h007;   // 2 MHz
         3'h3: ps_mask = 9'h00F;   // 1 MHz
         3'h2: ps_mask = 9'h01F;   // 500 kHz
         3'h1: ps_mask = 9'h03F;   // 250 kHz
         default: ps_mask = 9'h1FF; // 31 kHz
      endcase
   endfunction
endpackage

// file: inc/osel_qclk_if.sv
// carrier between the clock core and the quarter divider
`timescale 1ns/1ps
interface osel_qclk_if;
   logic tick;
   logic qclk;
   modport core (output tick, input qclk);
   modport div (input tick, output qclk);
endinterface

// file: hw/osel_div4.sv
// free-running divide-by-four of the active oscillator ticks
`timescale 1ns/1ps
module osel_div4 (
   input wire logic clk_i,
   input wire logic rst_b_i,
   osel_qclk_if.div q_if
);
   logic [1:0] cnt;

   // ------------------------------------------------------------
   // divider
   // ------------------------------------------------------------
   // glitch-free divider
   // msb of a 2-bit counter: two ticks high, two low, from a flop
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt <= 2'h0;
      end else if (q_if.tick) begin
         cnt <= cnt + 2'h1;
      end
   end

   assign q_if.qclk = cnt[1];
endmodule // osel_div4

// file: tb/osel_osc_model.sv
// behavioural oscillators, crystal and clock source beside the clock block
`timescale 1ns/1ps
module osel_osc_model (
   input wire logic clk_i,
   input wire logic pri_en_i,
   input wire logic sec_en_i,
   input wire logic slow_en_i,
   input wire logic fast_en_i,
   output logic osc_in_o,
   output logic sec_tick_o,
   output logic slow_tick_o,
   output logic fast_tick_o
);
   int cnt = 0;
   // one driver per output; known levels from time zero
   logic osc_lvl = 1'b0;
   logic sec_q = 1'b0;
   logic slow_q = 1'b0;
   logic fast_q = 1'b0;
   assign osc_in_o = osc_lvl;
   assign sec_tick_o = sec_q;
   assign slow_tick_o = slow_q;
   assign fast_tick_o = fast_q;
   // ------------------------------------------------------------
   // oscillator sources
   // ------------------------------------------------------------
   // one process: the watch crystal and slow sources count off the same free phase counter
   always @(posedge clk_i) begin
      cnt <= cnt + 1;
      // crystal stands still while the primary oscillator enable is off
      if (pri_en_i) osc_lvl <= ~osc_lvl;
      // watch crystal ticks only while enabled
      sec_q <= sec_en_i && (cnt % 16 == 0);
      // slow oscillator ticks only while enabled
      slow_q <= slow_en_i && (cnt % 8 == 0);
      // fast oscillator, one tick per cycle while enabled
      fast_q <= fast_en_i;
   end
endmodule // osel_osc_model

// file: tb/osel_top_tb.sv
// self-checking bench of the oscillator source enable logic
`timescale 1ns/1ps
module osel_top_tb;
   import osel_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic gpio_out = 1'b0;
   logic gpio_oe_b = 1'b1;
   logic [31:0] hrdata;
   logic hreadyout, hresp, osc_out, osc_out_oe_b, in_gpio, pri_en, sec_en, slow_en, fast_en;
   logic slw_tick, sys_tick, osc_in, sec_tk, slow_tk, fast_tk, last_out;
   logic [1:0] amp_gain;
   osel_mode_t mode;
   int miscompares = 0;
   int num_checks = 0;
   int n_sys = 0;
   int n_slw = 0;
   int n_tog = 0;
   logic [31:0] tab [17] = '{32'h0800_2C40, 32'h0000_2C50, 32'h1800_2C50, 32'h0801_2C50, 32'h0C00_2C70,
      32'h0800_2250, 32'h0800_A260, 32'h0800_2E60, 32'h0A00_2050, 32'h08C0_2010, 32'h08C0_2C20,
      32'h0900_0C40, 32'h0900_0D00, 32'h0900_4D80, 32'h0900_2D40, 32'h0800_0D40, 32'h0900_0E20};
   logic [31:0] d, s;

   always #5 mclk_i = ~mclk_i;

   osel_top #(.FAST_SETTLE_CYC(2)) dut_u (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
      .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .osc_in_i(osc_in), .sec_osc_tick_i(sec_tk),
      .slow_osc_tick_i(slow_tk), .fast_osc_tick_i(fast_tk), .gpio_out_i(gpio_out), .gpio_oe_b_i(gpio_oe_b),
      .osc_out_o(osc_out), .osc_out_oe_b_o(osc_out_oe_b), .osc_in_is_gpio_o(in_gpio),
      .primary_osc_en_o(pri_en), .amp_gain_o(amp_gain), .sec_osc_en_o(sec_en), .slow_osc_en_o(slow_en),
      .fast_osc_en_o(fast_en), .slow_timers_tick_o(slw_tick), .sys_tick_o(sys_tick),
      .primary_osc_mode_o(mode));

   osel_osc_model osc_u (.clk_i(mclk_i), .pri_en_i(pri_en), .sec_en_i(sec_en), .slow_en_i(slow_en),
      .fast_en_i(fast_en), .osc_in_o(osc_in), .sec_tick_o(sec_tk), .slow_tick_o(slow_tk),
      .fast_tick_o(fast_tk));

   // ------------------------------------------------------------
   // event counters of the tick and pin outputs
   // ------------------------------------------------------------
   always @(posedge mclk_i) begin
      last_out <= osc_out;
      // non-blocking so readers at this edge all see the same count
      if (sys_tick === 1'b1) n_sys <= n_sys + 1;
      if (slw_tick === 1'b1) n_slw <= n_slw + 1;
      if (osc_out !== last_out) n_tog <= n_tog + 1;
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask

   // one single transfer; entered just after a rising edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge mclk_i); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk_i); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] x;
      bus(1'b1, a, wd, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] rv);
      bus(1'b0, a, 32'h0, rv);
   endtask

   task automatic cfgset(input logic [31:0] cf, input logic [31:0] ct);
      wr(CFG_OFS, cf);
      wr(CTRL_OFS, ct);
      wt(8);
   endtask

   // counts ticks and pin toggles over 512 cycles; a negative toggle count skips the pin
   task automatic meas(input logic [31:0] cf, input logic [31:0] ct, input int es, input int el, input int et);
      int s0;
      int l0;
      int t0;
      cfgset(cf, ct);
      s0 = n_sys;
      l0 = n_slw;
      t0 = n_tog;
      wt(512);
      s0 = n_sys - s0;
      l0 = n_slw - l0;
      t0 = n_tog - t0;
      chk(32'(s0 >= es - 2 && s0 <= es + 2), 32'h1);
      chk(32'(l0 >= el - 2 && l0 <= el + 2), 32'h1);
      if (et >= 0) chk(32'(t0 >= et - 2 && t0 <= et + 2), 32'h1);
      if (et >= 0) chk({31'h0, osc_out_oe_b}, 32'h0);
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge mclk_i);
      chk({28'h0, pri_en, sec_en, slow_en, fast_en}, 32'h0);
      rst_b_i <= 1'b1;
      wt(4);
      rd(CFG_OFS, d);
      chk(d, {23'h0, CFG_RST});
      rd(CTRL_OFS, d);
      chk({29'h0, d[4:2]}, 32'h3);
      chk({30'h0, d[1:0]}, {30'h0, CSS_PRIMARY});
      rd(STAT_OFS, d);
      chk(d, 32'h28);
      chk({31'h0, hresp}, 32'h0);
      // unused bits, unmapped place and read-only status
      wr(CTRL_OFS, 32'hFFFF_FE2C);
      rd(CTRL_OFS, d);
      chk(d, 32'h2C);
      wr(8'h0C, 32'h1FF);
      rd(8'h0C, d);
      chk(d, RD_ZERO);
      rd(STAT_OFS, s);
      wr(STAT_OFS, ~s);
      rd(STAT_OFS, d);
      chk(d, s);
      // every mode code and the crystal gains
      for (int m = 0; m < 13; m++) begin
         wr(CFG_OFS, 32'h80 | 32'(m));
         wt(4);
         chk({28'h0, mode}, 32'(m));
         if (m < 3) chk({30'h0, amp_gain}, 32'(m + 1));
      end
      // enable conditions, each row cfg, ctrl, then sec, primary, fast, slow
      for (int i = 0; i < 17; i++) begin
         cfgset({20'h0, tab[i][31:20]}, {20'h0, tab[i][19:8]});
         rd(STAT_OFS, d);
         chk({28'h0, sec_en, pri_en, fast_en, slow_en}, {28'h0, tab[i][7:4]});
         chk({28'h0, d[4:1]}, {28'h0, tab[i][7:4]});
         chk({31'h0, d[0]}, {31'h0, tab[i][5]});
      end
      // out pin as general io in internal and rc modes
      gpio_out <= 1'b1;
      gpio_oe_b <= 1'b0;
      cfgset(32'h08B, 32'h02C);
      chk({29'h0, osc_out, osc_out_oe_b, in_gpio}, 32'h5);
      gpio_out <= 1'b0;
      gpio_oe_b <= 1'b1;
      cfgset(32'h083, 32'h02C);
      chk({29'h0, osc_out, osc_out_oe_b, in_gpio}, 32'h2);
      // postscaler outputs, slow source choice and quarter clocks
      for (int i = 1; i < 8; i++) meas(32'h080, 32'h22 | 32'(i << 2), 512 >> (7 - i), 0, -1);
      meas(32'h080, 32'hA2, 1, 0, -1);
      meas(32'h080, 32'h22, 64, 64, -1);
      meas(32'h08C, 32'h3C, 512, 0, 256);
      meas(32'h084, 32'h2C, 256, 0, 128);
      // high power setting covers the 50 MHz model clock
      meas(32'h08A, 32'h2C, 256, 0, 128);
      meas(32'h080, 32'h6D, 32, 0, -1);
      test_done();
   end

   // watchdog against a hung handshake; the tests need about 7,200 cycles
   initial begin
      #200_000;
      miscompares++;
      test_done();
   end
endmodule // osel_top_tb
